// ### verilog/opx_decode.sv
// decode stage: flexible second operand, fp status moves, fixed convert
// assumes: requests come from fetch on i_core_clk, answers go to execute
`timescale 1ns/10ps
`include "opx_defs.svh"
module opx_decode (
    input  wire logic             i_core_clk, // core clock, 100 MHz
    input  wire logic             i_rst,      // async reset, active high
    input  wire opx_pkg::opx_req_t i_req,     // decode request from fetch
    output opx_pkg::opx_rsp_t     o_rsp,      // answer to execute
    output logic [31:0]           o_fp_status_control_reg // fp status and control
);
    opx_pkg::opx_rsp_t rsp_r;
    opx_pkg::opx_rsp_t rsp_nxt;
    logic [31:0]       fp_status_control_reg_r;
    logic [31:0]       fp_status_control_reg_nxt;
    logic [31:0]       imm_val_w;
    logic              imm_rot_w;
    logic              imm_undef_w;
    logic [31:0]       rm_w;
    logic [7:0]        imm8_w;
    logic [1:0]        rep_w;
    logic              data_imm_w;
    logic              data_reg_w;
    logic              plain_reg_w;
    logic              logic_imm_s_w;
    logic              branch_w;
    logic              from_fp_w;
    logic              from_fp_core_w;
    logic              to_fp_w;
    logic              cvt_w;
    logic [15:0]       fix_w;
    logic [31:0]       seed_ref_w;
    logic [4:0]        rot_amt_w;
    logic [31:0]       rot_ref_w;

    opx_imm_expand u_imm (
        .i_imm12   (i_req.imm12),
        .o_value   (imm_val_w),
        .o_rotated (imm_rot_w),
        .o_undef   (imm_undef_w)
    );

    // float to signed 16-bit fixed, truncating, saturating, nan gives zero
    function automatic logic [15:0] f2fix(input logic [31:0] f,
                                          input logic [4:0]  fb);
        logic [7:0]        ex;
        logic [23:0]       man;
        logic signed [9:0] sh;
        logic [9:0]        nsh;
        logic [23:0]       mag;
        logic [15:0]       res;
        ex  = f[30:23];
        man = {1'b1, f[22:0]};
        sh  = $signed({2'h0, ex}) + $signed({5'h00, fb}) - `OPX_F32_BIAS_SH;
        nsh = 10'h000 - sh;
        mag = 24'h00_0000;
        if (ex == 8'hff && f[22:0] != 23'h00_0000)
            mag = 24'h00_0000;
        else if (ex == 8'h00)
            mag = 24'h00_0000;
        else if (sh >= 0)
            mag = 24'hff_ffff;
        else if (nsh < `OPX_MAN_BITS)
            mag = man >> nsh[4:0];
        if (!f[31])
            res = (mag > `OPX_FIX_POS_MAX) ? 16'h7fff : mag[15:0];
        else if (mag > `OPX_FIX_NEG_MAX)
            res = 16'h8000;
        else
            res = ~mag[15:0] + 16'h0001;
        return res;
    endfunction

    assign rm_w           = i_req.rm_val;
    assign imm8_w         = i_req.imm12[7:0];
    assign rep_w          = i_req.imm12[`OPX_IMM_REP_HI:`OPX_IMM_REP_LO];
    assign data_imm_w     = i_req.valid && i_req.op == opx_pkg::OPX_OP_DATA
                            && i_req.use_imm;
    assign data_reg_w     = i_req.valid && i_req.op == opx_pkg::OPX_OP_DATA
                            && !i_req.use_imm;
    assign plain_reg_w    = data_reg_w && i_req.shift == opx_pkg::OPX_SH_LSL
                            && i_req.shift_amt == 5'h00;
    assign logic_imm_s_w  = data_imm_w && i_req.set_flags && i_req.logical;
    assign branch_w       = i_req.valid && i_req.op == opx_pkg::OPX_OP_BRANCH;
    assign from_fp_w      = i_req.valid && i_req.op == opx_pkg::OPX_OP_FROM_FP;
    assign from_fp_core_w = from_fp_w && i_req.rt != `OPX_PC_REG;
    assign to_fp_w        = i_req.valid && i_req.op == opx_pkg::OPX_OP_TO_FP;
    assign cvt_w          = i_req.valid && i_req.op == opx_pkg::OPX_OP_CVT;
    assign fix_w          = f2fix(rm_w, i_req.fbits);
    // independent rotate built from two shifts, read only by the checks below
    assign seed_ref_w     = {24'h00_0000, 1'b1, imm8_w[6:0]};
    assign rot_amt_w      = i_req.imm12[`OPX_IMM_ROT_HI:`OPX_IMM_ROT_LO];
    assign rot_ref_w      = (seed_ref_w >> rot_amt_w)
                            | (seed_ref_w << (6'h20 - {1'b0, rot_amt_w}));

    always_comb
    begin
        rsp_nxt       = '0;
        fp_status_control_reg_nxt = fp_status_control_reg_r;
        rsp_nxt.valid = i_req.valid;
        if (i_req.valid)
        begin
            unique case (i_req.op)
                opx_pkg::OPX_OP_NONE:
                begin
                    rsp_nxt.valid = 1'b1;
                end
                opx_pkg::OPX_OP_DATA:
                begin
                    rsp_nxt.res_we = 1'b1;
                    if (i_req.use_imm)
                    begin
                        rsp_nxt.operand = imm_val_w;
                        rsp_nxt.undef   = imm_undef_w;
                        rsp_nxt.res_we  = !imm_undef_w;
                        // only the shifted form drives carry, others keep it
                        if (i_req.set_flags && i_req.logical && imm_rot_w)
                        begin
                            rsp_nxt.flag_we[`OPX_FLAG_C] = 1'b1;
                            rsp_nxt.flags[`OPX_FLAG_C]   = imm_val_w[31];
                        end
                    end
                    else
                    begin
                        // shifter sits in execute; it gets rm untouched
                        rsp_nxt.operand       = rm_w;
                        rsp_nxt.shift_pending = !plain_reg_w;
                    end
                end
                opx_pkg::OPX_OP_BRANCH:
                begin
                    rsp_nxt.operand   = {rm_w[31:1], 1'b0};
                    rsp_nxt.res_we    = rm_w[0];
                    rsp_nxt.isa_fault = !rm_w[0];
                end
                opx_pkg::OPX_OP_FROM_FP:
                begin
                    if (i_req.rt == `OPX_PC_REG)
                    begin
                        rsp_nxt.flag_we = 4'hf;
                        rsp_nxt.flags = fp_status_control_reg_r[`OPX_COND_HI:`OPX_COND_LO];
                    end
                    else
                    begin
                        rsp_nxt.operand = fp_status_control_reg_r;
                        rsp_nxt.res_we  = 1'b1;
                    end
                end
                opx_pkg::OPX_OP_TO_FP:
                begin
                    fp_status_control_reg_nxt = rm_w;
                    rsp_nxt.operand = rm_w;
                end
                opx_pkg::OPX_OP_CVT:
                begin
                    // flag_we stays clear: integer flags untouched
                    rsp_nxt.operand = {{16{fix_w[15]}}, fix_w};
                    rsp_nxt.res_we  = 1'b1;
                end
                default:
                begin
                    rsp_nxt.undef = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rsp_r   <= '0;
            fp_status_control_reg_r <= `OPX_FP_STATUS_RST;
        end
        else
        begin
            rsp_r   <= rsp_nxt;
            fp_status_control_reg_r <= fp_status_control_reg_nxt;
        end
    end

    assign o_rsp   = rsp_r;
    assign o_fp_status_control_reg = fp_status_control_reg_r;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_fp_write;
        to_fp_w;
    endsequence

    sequence s_fp_read_back;
        s_fp_write ##1 from_fp_core_w;
    endsequence

    a_answer_latency: assert property (i_req.valid |=> o_rsp.valid)
        else $error("answer missing one cycle after request");

    a_shift_form: assert property (
        data_imm_w && i_req.imm12[11:10] != 2'h0
        |=> o_rsp.operand > `OPX_SMALL_MAX && !o_rsp.undef
            && $countones(o_rsp.operand) == 1 + $countones($past(imm8_w) & 8'h7f))
        else $error("shifted constant expanded wrongly");

    a_lanes_even: assert property (
        data_imm_w && i_req.imm12[11:10] == 2'h0 && rep_w == 2'h1 && imm8_w != 8'h00
        |=> o_rsp.operand == {8'h00, $past(imm8_w), 8'h00, $past(imm8_w)})
        else $error("lanes zero and two pattern wrong");

    a_lanes_odd: assert property (
        data_imm_w && i_req.imm12[11:10] == 2'h0 && rep_w == 2'h2 && imm8_w != 8'h00
        |=> o_rsp.operand == {$past(imm8_w), 8'h00, $past(imm8_w), 8'h00})
        else $error("lanes one and three pattern wrong");

    a_lanes_all: assert property (
        data_imm_w && i_req.imm12[11:10] == 2'h0 && rep_w == 2'h3 && imm8_w != 8'h00
        |=> o_rsp.operand == {4{$past(imm8_w)}})
        else $error("all-lane pattern wrong");

    a_carry_taken: assert property (
        logic_imm_s_w && i_req.imm12[11:10] != 2'h0
        |=> o_rsp.flag_we == 4'h2 && o_rsp.flags[`OPX_FLAG_C] == o_rsp.operand[31])
        else $error("carry not taken from bit 31");

    a_carry_kept: assert property (
        logic_imm_s_w && i_req.imm12[11:10] == 2'h0 |=> o_rsp.flag_we == 4'h0)
        else $error("carry written for a non-shifted constant");

    a_isa_bit: assert property (
        branch_w |=> o_rsp.isa_fault == !$past(rm_w[0]) && !o_rsp.operand[0]
                     && o_rsp.res_we != o_rsp.isa_fault)
        else $error("instruction-set bit mishandled");

    a_fp_to_flags: assert property (
        from_fp_w && i_req.rt == `OPX_PC_REG
        |=> o_rsp.flag_we == 4'hf && !o_rsp.res_we
            && o_rsp.flags == o_fp_status_control_reg[`OPX_COND_HI:`OPX_COND_LO])
        else $error("fp status condition bits not copied");

    a_fp_read_back: assert property (
        s_fp_read_back |=> o_rsp.operand == $past(rm_w, 2) && o_rsp.res_we)
        else $error("core register copy of fp status wrong");

    a_fp_write: assert property (s_fp_write |=> o_fp_status_control_reg == $past(rm_w))
        else $error("fp status not written");

    a_fp_hold: assert property (!to_fp_w |=> $stable(o_fp_status_control_reg))
        else $error("fp status changed without a move to it");

    a_cvt_flags: assert property (
        cvt_w |=> o_rsp.flag_we == 4'h0 && o_rsp.res_we
                  && o_rsp.operand[31:16] == {16{o_rsp.operand[15]}})
        else $error("convert touched flags or lost sign extension");

    a_reg_plain: assert property (
        plain_reg_w |=> o_rsp.operand == $past(rm_w) && !o_rsp.shift_pending)
        else $error("unshifted register operand altered");

    a_undef_flag: assert property (
        data_imm_w && imm_undef_w
        |=> o_rsp.undef && o_rsp.operand == 32'h0000_0000
            && o_rsp.flag_we == 4'h0 && !o_rsp.res_we)
        else $error("undefined constant not reported");

    a_shift_value: assert property (
        data_imm_w && i_req.imm12[11:10] != 2'h0 |=> o_rsp.operand == $past(rot_ref_w))
        else $error("shifted constant differs from rotate reference");

    a_byte_form: assert property (
        data_imm_w && i_req.imm12[11:8] == 4'h0
        |=> o_rsp.operand == {24'h00_0000, $past(imm8_w)} && !o_rsp.undef)
        else $error("plain byte constant expanded wrongly");

    a_carry_value: assert property (
        logic_imm_s_w && i_req.imm12[11:10] != 2'h0
        |=> o_rsp.flags[`OPX_FLAG_C] == $past(rot_ref_w[31]))
        else $error("carry differs from bit 31 of rotate reference");

    a_plain_no_flags: assert property (
        data_imm_w && !(i_req.set_flags && i_req.logical) |=> o_rsp.flag_we == 4'h0)
        else $error("constant without flag setting wrote flags");

    a_reg_shifted: assert property (
        data_reg_w && !plain_reg_w
        |=> o_rsp.shift_pending && o_rsp.operand == $past(rm_w) && o_rsp.flag_we == 4'h0)
        else $error("shifted register operand not passed on");

    a_fp_core_copy: assert property (
        from_fp_core_w |=> o_rsp.operand == $past(o_fp_status_control_reg)
            && o_rsp.res_we && o_rsp.flag_we == 4'h0)
        else $error("fp status not copied to core register");

    a_to_fp_quiet: assert property (
        to_fp_w |=> !o_rsp.res_we && o_rsp.flag_we == 4'h0 && !o_rsp.undef)
        else $error("move to fp status wrote a result or flags");

    a_idle_answer: assert property (!i_req.valid |=> o_rsp == '0)
        else $error("answer present without a request");

    a_empty_op: assert property (
        i_req.valid && i_req.op == opx_pkg::OPX_OP_NONE
        |=> o_rsp.valid && !o_rsp.undef && !o_rsp.res_we && o_rsp.flag_we == 4'h0)
        else $error("empty operation produced an effect");

    a_bad_op: assert property (
        i_req.valid && i_req.op > opx_pkg::OPX_OP_CVT |=> o_rsp.undef && !o_rsp.res_we)
        else $error("illegal operation not reported undefined");
endmodule

// ### verilog/opx_defs.svh
// constants for the second-operand decoder
// assumes: included by bare name from the decode files
`ifndef OPX_DEFS_SVH
`define OPX_DEFS_SVH
`define OPX_IMM_ROT_HI   11
`define OPX_IMM_ROT_LO   7
`define OPX_IMM_REP_HI   9
`define OPX_IMM_REP_LO   8
`define OPX_SMALL_MAX    32'h0000_00ff
`define OPX_FLAG_N       3
`define OPX_FLAG_Z       2
`define OPX_FLAG_C       1
`define OPX_FLAG_V       0
`define OPX_COND_HI      31
`define OPX_COND_LO      28
`define OPX_PC_REG       4'hf
`define OPX_FP_STATUS_RST 32'h0000_0000
`define OPX_F32_BIAS_SH  10'sh096
`define OPX_FIX_POS_MAX  24'h00_7fff
`define OPX_FIX_NEG_MAX  24'h00_8000
`define OPX_MAN_BITS     10'h018
`endif

// ### verilog/opx_pkg.sv
// types shared by the second-operand decoder, the execute model and the bench
// assumes: opx_defs.svh holds the numeric constants
package opx_pkg;
    typedef enum logic [2:0] {
        OPX_OP_NONE,
        OPX_OP_DATA,
        OPX_OP_BRANCH,
        OPX_OP_FROM_FP,
        OPX_OP_TO_FP,
        OPX_OP_CVT
    } opx_op_t;

    typedef enum logic [1:0] {
        OPX_SH_LSL,
        OPX_SH_LSR,
        OPX_SH_ASR,
        OPX_SH_ROR
    } opx_shift_t;

    typedef struct packed {
        logic       valid;
        opx_op_t    op;
        logic       set_flags;
        logic       logical;
        logic       use_imm;
        logic [11:0] imm12;
        logic [31:0] rm_val;
        opx_shift_t shift;
        logic [4:0] shift_amt;
        logic [3:0] rt;
        logic [4:0] fbits;
    } opx_req_t;

    typedef struct packed {
        logic       valid;
        logic [31:0] operand;
        logic [3:0] flag_we;
        logic [3:0] flags;
        logic       res_we;
        logic       undef;
        logic       isa_fault;
        logic       shift_pending;
    } opx_rsp_t;
endpackage

// ### verilog/opx_imm_expand.sv
// expands the 12-bit encoded second-operand constant to 32 bits
// assumes: purely combinational, the caller registers the result
`timescale 1ns/10ps
`include "opx_defs.svh"
module opx_imm_expand (
    input  wire logic [11:0] i_imm12,   // encoded constant
    output logic [31:0]      o_value,   // expanded constant
    output logic             o_rotated, // shifted 8-bit form above 255
    output logic             o_undef    // matches no permitted form
);
    logic [7:0]  byte_w;
    logic [31:0] seed_w;
    logic [63:0] dbl_w;

    always_comb
    begin
        byte_w    = i_imm12[7:0];
        seed_w    = {24'h00_0000, 1'b1, i_imm12[6:0]};
        dbl_w     = {seed_w, seed_w} >> i_imm12[`OPX_IMM_ROT_HI:`OPX_IMM_ROT_LO];
        o_value   = 32'h0000_0000;
        o_rotated = 1'b0;
        o_undef   = 1'b0;
        if (i_imm12[`OPX_IMM_ROT_HI:`OPX_IMM_ROT_HI-1] != 2'h0)
        begin
            // rotating right by 8..31 is the same as a left shift of the byte by 24..1
            o_value   = dbl_w[31:0];
            o_rotated = (dbl_w[31:0] > `OPX_SMALL_MAX);
        end
        else
        begin
            unique case (i_imm12[`OPX_IMM_REP_HI:`OPX_IMM_REP_LO])
                2'h0: o_value = {24'h00_0000, byte_w};
                2'h1: o_value = {8'h00, byte_w, 8'h00, byte_w};
                2'h2: o_value = {byte_w, 8'h00, byte_w, 8'h00};
                2'h3: o_value = {4{byte_w}};
            endcase
            // a zero replicated byte has no defined meaning
            if (i_imm12[`OPX_IMM_REP_HI:`OPX_IMM_REP_LO] != 2'h0 && byte_w == 8'h00)
            begin
                o_undef = 1'b1;
                o_value = 32'h0000_0000;
            end
        end
    end
endmodule

// ### bench/opx_exec_model.sv
// execute-side model: holds the condition flags fed by decoder answers
// assumes: shares clock and reset with the decoder
`timescale 1ns/10ps
module opx_exec_model (
    input  wire logic              i_core_clk, // core clock
    input  wire logic              i_rst,      // async reset, active high
    input  wire opx_pkg::opx_rsp_t i_rsp,      // decoder answer
    output logic [3:0]             o_flags     // held N Z C V
);
    logic [3:0] flags_r;
    logic [3:0] flags_nxt;

    always_comb
    begin
        flags_nxt = flags_r;
        // flags not written keep their old value
        if (i_rsp.valid)
            flags_nxt = (flags_r & ~i_rsp.flag_we) | (i_rsp.flags & i_rsp.flag_we);
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            flags_r <= 4'h0;
        else
            flags_r <= flags_nxt;
    end

    assign o_flags = flags_r;
endmodule

// ### bench/flexible_second_operand_immediate_expander_bench.sv
// self-checking bench for the second-operand decoder
// assumes: opx_pkg compiled first; the execute model holds the flags
`timescale 1ns/10ps
module flexible_second_operand_immediate_expander_bench;
    logic              clk;
    logic              rst;
    opx_pkg::opx_req_t req;
    opx_pkg::opx_rsp_t rsp;
    logic [31:0]       fp_stat;
    logic [3:0]        xflags;
    int                bad_count;
    int                samples_checked;
    int                cycles;

    opx_decode dut (.i_core_clk(clk), .i_rst(rst), .i_req(req), .o_rsp(rsp),
                    .o_fp_status_control_reg(fp_stat));
    opx_exec_model exe (.i_core_clk(clk), .i_rst(rst), .i_rsp(rsp), .o_flags(xflags));

    always #5 clk = ~clk;

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // run is under a hundred cycles; this only cuts a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // status word: valid undef isa_fault shift_pending res_we flag_we
    task automatic chk_rsp(input logic [31:0] op, input logic [8:0] st);
        chk(rsp.operand, op);
        chk({23'h0, rsp.valid, rsp.undef, rsp.isa_fault, rsp.shift_pending, rsp.res_we,
             rsp.flag_we}, {23'h0, st});
    endtask

    function automatic opx_pkg::opx_req_t mk(input opx_pkg::opx_op_t op, input logic [31:0] rm);
        opx_pkg::opx_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.rm_val = rm;
        return r;
    endfunction

    function automatic logic [31:0] exp_imm(input logic [11:0] c);
        logic [31:0] b;
        b = {24'h0, 1'b1, c[6:0]};
        if (c[11:10] != 2'h0)
            return (b >> c[11:7]) | (b << (6'd32 - {1'b0, c[11:7]}));
        case (c[9:8])
            2'h0: return {24'h0, c[7:0]};
            2'h1: return {8'h0, c[7:0], 8'h0, c[7:0]};
            2'h2: return {c[7:0], 8'h0, c[7:0], 8'h0};
            default: return {4{c[7:0]}};
        endcase
    endfunction

    task automatic issue(input opx_pkg::opx_req_t r);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask

    // move-to then move-from back to back, then into the flags
    task automatic t_fp;
        opx_pkg::opx_req_t a;
        opx_pkg::opx_req_t b;
        a = mk(opx_pkg::OPX_OP_TO_FP, 32'ha000_0000);
        b = mk(opx_pkg::OPX_OP_FROM_FP, 32'h0);
        b.rt = 4'h5;
        @(posedge clk);
        req <= a;
        @(posedge clk);
        req <= b;
        #1;
        chk(fp_stat, 32'ha000_0000);
        chk_rsp(32'ha000_0000, 9'h100);
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk_rsp(32'ha000_0000, 9'h110);
        b.rt = 4'hf;
        issue(b);
        chk({24'h0, rsp.flag_we, rsp.flags}, 32'hfa);
        @(posedge clk);
        #1;
        chk({28'h0, xflags}, 32'ha);
    endtask

    // carry starts at one so a wrongly cleared carry shows
    task automatic t_imm;
        logic [11:0] tab [10] = '{12'h1a5, 12'h2a5, 12'h3a5, 12'h07f, 12'h100,
                                  12'h4ff, 12'h2c3, 12'h47f, 12'hfff, 12'h8a5};
        opx_pkg::opx_req_t r;
        logic [31:0] e;
        logic c;
        c = 1'b1;
        r = mk(opx_pkg::OPX_OP_DATA, 32'h0);
        r.set_flags = 1'b1;
        r.logical = 1'b1;
        r.use_imm = 1'b1;
        foreach (tab[i])
        begin
            r.imm12 = tab[i];
            e = exp_imm(tab[i]);
            issue(r);
            if (tab[i][11:10] != 2'h0)
            begin
                c = e[31];
                chk_rsp(e, 9'h112);
                chk({31'h0, rsp.flags[1]}, {31'h0, c});
            end
            else if (tab[i][9:8] != 2'h0 && tab[i][7:0] == 8'h00)
                chk_rsp(32'h0, 9'h180);
            else
                chk_rsp(e, 9'h110);
            @(posedge clk);
            #1;
            chk({31'h0, xflags[1]}, {31'h0, c});
        end
        chk(fp_stat, 32'ha000_0000);
    endtask

    task automatic t_reg_branch;
        opx_pkg::opx_req_t r;
        r = mk(opx_pkg::OPX_OP_DATA, 32'h8765_4321);
        issue(r);
        chk({rsp.operand[30:0], rsp.shift_pending}, 32'h0eca_8642);
        r.shift_amt = 5'h3;
        issue(r);
        chk({31'h0, rsp.shift_pending}, 32'h1);
        r = mk(opx_pkg::OPX_OP_BRANCH, 32'h0000_2001);
        issue(r);
        chk_rsp(32'h0000_2000, 9'h110);
        r.rm_val = 32'h0000_2000;
        issue(r);
        chk_rsp(32'h0000_2000, 9'h140);
        r = mk(opx_pkg::opx_op_t'(3'h6), 32'h1234_5678);
        issue(r);
        chk_rsp(32'h0, 9'h180);
        r = mk(opx_pkg::OPX_OP_NONE, 32'h1234_5678);
        issue(r);
        chk_rsp(32'h0, 9'h100);
    endtask

    // mid-run reset must clear fp status, the answer and the held flags
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(fp_stat, 32'h0);
        chk_rsp(32'h0, 9'h000);
        chk({28'h0, xflags}, 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        issue(mk(opx_pkg::OPX_OP_TO_FP, 32'h5000_0000));
        chk(fp_stat, 32'h5000_0000);
    endtask

    task automatic t_cvt;
        logic [31:0] fin [5] = '{32'h4020_0000, 32'hbf80_0000, 32'h4974_2400,
                                 32'hc0e0_0000, 32'h3f40_0000};
        logic [4:0]  fb [5] = '{5'h04, 5'h00, 5'h00, 5'h0c, 5'h01};
        logic [31:0] fx [5] = '{32'h0000_0028, 32'hffff_ffff, 32'h0000_7fff,
                                32'hffff_9000, 32'h0000_0001};
        opx_pkg::opx_req_t r;
        logic [3:0] held;
        held = xflags;
        foreach (fin[i])
        begin
            r = mk(opx_pkg::OPX_OP_CVT, fin[i]);
            r.fbits = fb[i];
            issue(r);
            chk_rsp(fx[i], 9'h110);
        end
        @(posedge clk);
        #1;
        chk({28'h0, xflags}, {28'h0, held});
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        #1;
        chk(fp_stat, 32'h0);
        chk_rsp(32'h0, 9'h000);
        @(posedge clk);
        rst <= 1'b0;
        t_fp();
        t_imm();
        t_reg_branch();
        t_cvt();
        t_reset();
        results();
    end
endmodule
